// ### hw/acq_strings_pkg.sv
package acq_strings_pkg;

	// String geometry
	localparam int STRING_BITS   = 32;
	localparam int TIMEBASE_BITS = 64;
	localparam int COUNT_BITS    = 27;
	localparam int MAX_CHANNELS  = 4;

	// Sampler channel string field positions
	localparam int SMP_LEVEL_LSB   = 0;
	localparam int SMP_LEVEL_MSB   = 9;
	localparam int SMP_SIGN_BIT    = 10;
	localparam int SMP_EDGE_BIT    = 11;
	localparam int SMP_ENABLE_BIT  = 12;
	localparam int SMP_OFFSET_LSB  = 13;
	localparam int SMP_OFFSET_MSB  = 23;
	localparam int SMP_X2_BIT      = 24;
	localparam int SMP_X5_BIT      = 25;
	localparam int SMP_X10_BIT     = 26;
	localparam int SMP_CLOSE_BIT   = 27;
	localparam int SMP_DITHER_BIT  = 28;

	// Trigger setup string field positions
	localparam int TRG_LEVEL_LSB  = 0;
	localparam int TRG_LEVEL_MSB  = 9;
	localparam int TRG_SIGN_BIT   = 10;
	localparam int TRG_SLOPE_BIT  = 11;
	localparam int TRG_ENABLE_BIT = 12;
	localparam int TRG_INVERT_BIT = 13;

	// Holdoff setup string field positions
	localparam int HLD_SRC_LSB   = 0;
	localparam int HLD_SRC_MSB   = 1;
	localparam int HLD_COUNT_LSB = 2;
	localparam int HLD_COUNT_MSB = 28;

	// Timebase words: first word carries pre count and post bits 0-6
	localparam int TB1_PRE_LSB   = 0;
	localparam int TB1_PRE_MSB   = 23;
	localparam int TB1_POST_LSB  = 25;
	localparam int TB1_POST_MSB  = 31;
	localparam int TB2_POST_LSB  = 0;
	localparam int TB2_POST_MSB  = 16;

	// Target select codes on the select pins
	typedef enum logic [2:0] {
		TGT_TRIGGER  = 3'h0,
		TGT_HOLDOFF  = 3'h1,
		TGT_TIMEBASE = 3'h2,
		TGT_IDLE     = 3'h3,
		TGT_SAMPLER0 = 3'h4,
		TGT_SAMPLER1 = 3'h5,
		TGT_SAMPLER2 = 3'h6,
		TGT_SAMPLER3 = 3'h7
	} target_type;

	typedef enum logic [1:0] {
		HOLD_UNUSED = 2'h0,
		HOLD_TIME   = 2'h1,
		HOLD_EVENTS = 2'h2,
		HOLD_OPTION = 2'h3
	} holdoff_src_type;

	typedef struct packed {
		logic [9:0]  trig_level;
		logic        level_sign;
		logic        edge_polarity;
		logic        trig_enable_n;
		logic [10:0] offset;
		logic        atten_stage_two_n;
		logic        atten_stage_five_n;
		logic        atten_stage_ten_n;
		logic        close_input_n;
		logic        dither;
	} sampler_ctrl_type;

	typedef struct packed {
		logic [9:0] trig_level;
		logic       level_sign;
		logic       slope;
		logic       trig_enable_n;
		logic       invert;
	} trigger_ctrl_type;

	typedef struct packed {
		holdoff_src_type source;
		logic [26:0]     count;
	} holdoff_ctrl_type;

	typedef struct packed {
		logic [23:0] pre_count;
		logic [23:0] post_count;
	} timebase_ctrl_type;

	// Values after reset: triggers disabled, attenuator open, all counts zero
	localparam sampler_ctrl_type SAMPLER_RESET = '{10'h000, 1'b0, 1'b0, 1'b1, 11'h000,
		1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	localparam trigger_ctrl_type TRIGGER_RESET = '{10'h000, 1'b0, 1'b0, 1'b1, 1'b0};
	localparam holdoff_ctrl_type HOLDOFF_RESET = '{HOLD_UNUSED, 27'h0000000};
	localparam timebase_ctrl_type TIMEBASE_RESET = '{24'h000000, 24'h000000};
	localparam logic [6:0] BIT_COUNT_RESET = 7'h00;

	// Gray count to binary, walking down from the top bit
	function automatic logic [COUNT_BITS-1:0] gray_to_binary(input logic [COUNT_BITS-1:0] g);
		logic [COUNT_BITS-1:0] b;
		b = g;
		for (int i = COUNT_BITS - 2; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction : gray_to_binary

endpackage : acq_strings_pkg

// ### hw/acq_serial_strings.sv
`timescale 1ns/1ps
// How it works
// - Each string enters bit 0 first and its top bit last.
// - Every sampler channel has its own latched string, set independently.
// - Sampler bits 0-9 give trigger level, bit 10 its sign, bit 11 the edge polarity.
// - Sampler bit 12 low enables the trigger, bits 13-23 the offset, bits 29-31 ignored.
// - Sampler bits 24-26 pick the x2, x5, x10 stages low true, 27 closes input, 28 dither.
// - Trigger string bits 0-9 level, bit 10 sign, bit 11 slope, high meaning positive.
// - Trigger string bit 12 low enables, bit 13 inverts, bits 14-31 ignored.
// - Holdoff bits 0-1 pick the source, bits 2-28 the count, bits 29-31 ignored.
// - Timebase word 1 holds pre count 0-23 at 0-23, ignores 24, post 0-6 at 25-31.
// - Timebase word 2 holds post count 7-23 at 0-16, joined with word 1, rest ignored.
// - Strings take effect on the latch strobe, timebase strings on a run/stop toggle.
// - Holdoff and timebase counts arrive in Gray code, sampler fields plain.
module acq_serial_strings
	import acq_strings_pkg::*;
#(
	parameter int CHANNELS = 2
)(
	// Clock and reset
	input  wire logic                               clock,
	input  wire logic                               rst_n,
	// Serial pins from the processor board
	input  wire logic                               shift_clock_pin,
	input  wire logic                               serial_data_pin,
	input  wire logic [2:0]                         target_select_pin,
	input  wire logic                               latch_strobe_pin,
	input  wire logic                               run_stop_pin,
	// Latched controls
	output acq_strings_pkg::sampler_ctrl_type       sampler_ctrl [CHANNELS],
	output acq_strings_pkg::trigger_ctrl_type       trigger_ctrl,
	output acq_strings_pkg::holdoff_ctrl_type       holdoff_ctrl,
	output acq_strings_pkg::timebase_ctrl_type      timebase_ctrl,
	output wire logic                               run_state,
	// Shift progress
	output wire logic [6:0]                         bit_count
);
	import acq_strings_pkg::*;

	// Synchroniser stages
	logic [4:0]  pin_meta_reg;
	logic [4:0]  pin_sync_reg;
	logic        shift_clock_last_reg;
	logic        strobe_last_reg;
	logic        run_last_reg;

	// Data paths
	logic [STRING_BITS-1:0]   shift_reg;
	logic [TIMEBASE_BITS-1:0] tb_shift_reg;
	logic [6:0]               bit_count_reg;
	logic [6:0]               bit_count_next;
	target_type               target_reg;

	// Latched state
	sampler_ctrl_type         sampler_reg [CHANNELS];
	trigger_ctrl_type         trigger_reg;
	holdoff_ctrl_type         holdoff_reg;
	timebase_ctrl_type        timebase_reg;

	// Decoded events
	logic        shift_clock_s;
	logic        serial_data_s;
	target_type  target_s;
	logic        strobe_s;
	logic        run_s;
	logic        shift_edge;
	logic        latch_edge;
	logic        run_toggle;
	logic        target_change;

	// Gray decode of the counts, combinational, taken into the stores on the strobe or the run/stop toggle
	logic [COUNT_BITS-1:0] holdoff_bin;
	logic [COUNT_BITS-1:0] pre_bin;
	logic [COUNT_BITS-1:0] post_bin;
	logic [STRING_BITS-1:0] tb_word1;
	logic [STRING_BITS-1:0] tb_word2;

	// Gray words before decoding
	logic [23:0]            pre_gray;
	logic [23:0]            post_gray;

	// Latch and shift enables, one per store; codes with no store fall through
	logic                   latch_trigger;
	logic                   latch_holdoff;
	logic [CHANNELS-1:0]    latch_sampler;
	logic                   shift_string;
	logic                   shift_timebase;

	// Two flops on every pin; the first stage feeds only the second
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pin_meta_reg <= 5'h00;
			pin_sync_reg <= 5'h00;
		end
		else
		begin
			pin_meta_reg <= {run_stop_pin, latch_strobe_pin, target_select_pin[0],
				serial_data_pin, shift_clock_pin};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// Target select bits 1-2 are synchronised separately to keep the flop vector short
	logic [1:0] sel_meta_reg;
	logic [1:0] sel_sync_reg;

	// Same two stages for the upper select bits
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			sel_meta_reg <= 2'h0;
			sel_sync_reg <= 2'h0;
		end
		else
		begin
			sel_meta_reg <= target_select_pin[2:1];
			sel_sync_reg <= sel_meta_reg;
		end
	end

	// Name the synchronised pins
	assign shift_clock_s = pin_sync_reg[0];
	assign serial_data_s = pin_sync_reg[1];
	assign target_s      = target_type'({sel_sync_reg, pin_sync_reg[2]});
	assign strobe_s      = pin_sync_reg[3];
	assign run_s         = pin_sync_reg[4];

	// Edge history, read only after the second stage
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			shift_clock_last_reg <= 1'b0;
			strobe_last_reg      <= 1'b0;
			run_last_reg         <= 1'b0;
		end
		else
		begin
			shift_clock_last_reg <= shift_clock_s;
			strobe_last_reg      <= strobe_s;
			run_last_reg         <= run_s;
		end
	end

	// Data and clock go through equal depth, so data is taken as it stood at the edge
	assign shift_edge    = shift_clock_s & ~shift_clock_last_reg;
	assign latch_edge    = strobe_s & ~strobe_last_reg;
	assign run_toggle    = run_s ^ run_last_reg;
	assign target_change = (target_s != target_reg);

	// Decode what a strobe or shift is aimed at; timebase and idle take no strobe
	assign latch_trigger  = latch_edge && (target_s == TGT_TRIGGER);
	assign latch_holdoff  = latch_edge && (target_s == TGT_HOLDOFF);
	assign shift_timebase = shift_edge && (target_s == TGT_TIMEBASE);
	assign shift_string   = shift_edge && (target_s != TGT_TIMEBASE)
		&& (target_s != TGT_IDLE);

	// Remember which string is being loaded
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			target_reg <= TGT_IDLE;
		else
			target_reg <= target_s;
	end

	// Shared string shifter: new bit enters the top, so bit 0 lands at the bottom
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			shift_reg <= '0;
		else if (shift_string)
			shift_reg <= {serial_data_s, shift_reg[STRING_BITS-1:1]};
	end

	// Timebase chain holds both words; the first word shifted ends at the bottom
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			tb_shift_reg <= '0;
		else if (shift_timebase)
			tb_shift_reg <= {serial_data_s, tb_shift_reg[TIMEBASE_BITS-1:1]};
	end

	// Bit progress, restarted when the target changes, on any rising strobe edge or on a run/stop toggle
	always_comb
	begin
		bit_count_next = bit_count_reg;
		if (target_change || latch_edge || run_toggle)
			bit_count_next = BIT_COUNT_RESET;
		else if (shift_edge && target_s != TGT_IDLE && bit_count_reg != 7'h7F)
			bit_count_next = bit_count_reg + 7'h01;
	end

	// Count register; saturates so a runaway stream never wraps to zero
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			bit_count_reg <= BIT_COUNT_RESET;
		else
			bit_count_reg <= bit_count_next;
	end

	// Split the timebase chain into its two words
	assign tb_word2 = tb_shift_reg[STRING_BITS-1:0];
	assign tb_word1 = tb_shift_reg[TIMEBASE_BITS-1:STRING_BITS];

	// Post count is spread over both words, its low seven bits in word 1
	assign pre_gray  = tb_word1[TB1_PRE_MSB:TB1_PRE_LSB];
	assign post_gray = {tb_word2[TB2_POST_MSB:TB2_POST_LSB],
		tb_word1[TB1_POST_MSB:TB1_POST_LSB]};

	// Counts are carried in Gray code and stored as binary
	assign holdoff_bin = gray_to_binary(shift_reg[HLD_COUNT_MSB:HLD_COUNT_LSB]);
	assign pre_bin     = gray_to_binary({3'h0, pre_gray});
	assign post_bin    = gray_to_binary({3'h0, post_gray});

	// One latched register per sampler channel
	generate
		for (genvar ch = 0; ch < CHANNELS; ch++)
		begin : g_sampler
			localparam logic [2:0] CODE = 3'(int'(TGT_SAMPLER0) + ch);

			// Strobe aimed at this channel only
			assign latch_sampler[ch] = latch_edge && target_s == target_type'(CODE);

			always_ff @(posedge clock)
			begin
				if (!rst_n)
					sampler_reg[ch] <= SAMPLER_RESET;
				else if (latch_sampler[ch])
				begin
					sampler_reg[ch].trig_level         <=
						shift_reg[SMP_LEVEL_MSB:SMP_LEVEL_LSB];
					sampler_reg[ch].level_sign         <= shift_reg[SMP_SIGN_BIT];
					sampler_reg[ch].edge_polarity      <= shift_reg[SMP_EDGE_BIT];
					sampler_reg[ch].trig_enable_n      <= shift_reg[SMP_ENABLE_BIT];
					sampler_reg[ch].offset             <=
						shift_reg[SMP_OFFSET_MSB:SMP_OFFSET_LSB];
					sampler_reg[ch].atten_stage_two_n  <= shift_reg[SMP_X2_BIT];
					sampler_reg[ch].atten_stage_five_n <= shift_reg[SMP_X5_BIT];
					sampler_reg[ch].atten_stage_ten_n  <= shift_reg[SMP_X10_BIT];
					sampler_reg[ch].close_input_n      <= shift_reg[SMP_CLOSE_BIT];
					sampler_reg[ch].dither             <= shift_reg[SMP_DITHER_BIT];
				end
			end

			// Output straight from the channel's flops
			assign sampler_ctrl[ch] = sampler_reg[ch];
		end
	endgenerate

	// Trigger setup latch; upper bits of the string are dropped
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			trigger_reg <= TRIGGER_RESET;
		else if (latch_trigger)
		begin
			trigger_reg.trig_level    <= shift_reg[TRG_LEVEL_MSB:TRG_LEVEL_LSB];
			trigger_reg.level_sign    <= shift_reg[TRG_SIGN_BIT];
			trigger_reg.slope         <= shift_reg[TRG_SLOPE_BIT];
			trigger_reg.trig_enable_n <= shift_reg[TRG_ENABLE_BIT];
			trigger_reg.invert        <= shift_reg[TRG_INVERT_BIT];
		end
	end

	// Holdoff setup latch
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			holdoff_reg <= HOLDOFF_RESET;
		else if (latch_holdoff)
		begin
			holdoff_reg.source <= holdoff_src_type'(shift_reg[HLD_SRC_MSB:HLD_SRC_LSB]);
			holdoff_reg.count  <= holdoff_bin;
		end
	end

	// Timebase words ignore the strobe and take effect on any run/stop change
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			timebase_reg <= TIMEBASE_RESET;
		else if (run_toggle)
		begin
			timebase_reg.pre_count  <= pre_bin[23:0];
			timebase_reg.post_count <= post_bin[23:0];
		end
	end

	// Run level is shown from the edge register, a clock after synchronising; starting capture is the processor's call
	assign run_state     = run_last_reg;
	assign trigger_ctrl  = trigger_reg;
	assign holdoff_ctrl  = holdoff_reg;
	assign timebase_ctrl = timebase_reg;
	assign bit_count     = bit_count_reg;

endmodule : acq_serial_strings

// ### dv/acq_strings_checker.sv
`timescale 1ns/1ps
module acq_strings_checker
	import acq_strings_pkg::*;
#(
	parameter int CHANNELS = 2
)(
	// Clock, reset and pins
	input wire logic                         clock,
	input wire logic                         rst_n,
	input wire logic                         shift_clock_pin,
	input wire logic                         serial_data_pin,
	input wire logic [2:0]                   target_select_pin,
	input wire logic                         latch_strobe_pin,
	input wire logic                         run_stop_pin,
	// Latched controls
	input acq_strings_pkg::sampler_ctrl_type  sampler_ctrl [CHANNELS],
	input acq_strings_pkg::trigger_ctrl_type  trigger_ctrl,
	input acq_strings_pkg::holdoff_ctrl_type  holdoff_ctrl,
	input acq_strings_pkg::timebase_ctrl_type timebase_ctrl,
	input wire logic                         run_state,
	input wire logic [6:0]                   bit_count
);
	default clocking cb @(posedge clock); endclocking

	// Reset forces inactive fields, triggers off
	reset_values_a: assert property (!rst_n |=> trigger_ctrl == TRIGGER_RESET
		&& holdoff_ctrl == HOLDOFF_RESET && timebase_ctrl == TIMEBASE_RESET)
		else $error("control fields not inactive after reset");
	sampler_reset_a: assert property (!rst_n |=> sampler_ctrl[0] == SAMPLER_RESET
		&& sampler_ctrl[CHANNELS-1] == SAMPLER_RESET) else $error("sampler not inactive");
	// Outputs move only three edges after a strobe aimed at them
	trig_latch_a: assert property (disable iff (!rst_n) $changed(trigger_ctrl) |->
		$past(latch_strobe_pin, 3) && $past(target_select_pin, 3) == TGT_TRIGGER)
		else $error("trigger string moved without its strobe");
	hold_latch_a: assert property (disable iff (!rst_n) $changed(holdoff_ctrl) |->
		$past(latch_strobe_pin, 3) && $past(target_select_pin, 3) == TGT_HOLDOFF)
		else $error("holdoff string moved without its strobe");
	chan0_latch_a: assert property (disable iff (!rst_n) $changed(sampler_ctrl[0]) |->
		$past(latch_strobe_pin, 3) && $past(target_select_pin, 3) == TGT_SAMPLER0)
		else $error("channel 0 moved without its strobe");
	chan1_latch_a: assert property (disable iff (!rst_n) $changed(sampler_ctrl[1]) |->
		$past(latch_strobe_pin, 3) && $past(target_select_pin, 3) == TGT_SAMPLER1)
		else $error("channel 1 moved without its strobe");
	// Window of three edges tolerates where the toggle lands
	tb_toggle_a: assert property (disable iff (!rst_n) $changed(timebase_ctrl) |->
		$past(run_stop_pin, 2) != $past(run_stop_pin, 5)) else $error("timebase moved untoggled");
	shift_count_a: assert property (disable iff (!rst_n) $rose(shift_clock_pin)
		&& bit_count < 7'h40 && target_select_pin != TGT_IDLE |-> ##4
		bit_count == $past(bit_count, 4) + 7'h01) else $error("shift not counted once");
	// Run level follows its pin through the two sync stages and the edge register
	run_level_a: assert property (disable iff (!rst_n) run_state == $past(run_stop_pin, 3))
		else $error("run level not three edges behind its pin");
endmodule : acq_strings_checker

bind acq_serial_strings acq_strings_checker #(.CHANNELS(CHANNELS)) chk_u (.clock(clock),
	.rst_n(rst_n), .shift_clock_pin(shift_clock_pin), .serial_data_pin(serial_data_pin),
	.target_select_pin(target_select_pin), .latch_strobe_pin(latch_strobe_pin),
	.run_stop_pin(run_stop_pin), .sampler_ctrl(sampler_ctrl), .trigger_ctrl(trigger_ctrl),
	.holdoff_ctrl(holdoff_ctrl), .timebase_ctrl(timebase_ctrl), .run_state(run_state),
	.bit_count(bit_count));

// ### dv/proc_model.sv
`timescale 1ns/1ps
module proc_model
	import acq_strings_pkg::*;
(
	// Clock
	input wire logic   clock,
	// Serial pins toward the strings
	output logic       shift_clock_pin,
	output logic       serial_data_pin,
	output logic [2:0] target_select_pin,
	output logic       latch_strobe_pin,
	output logic       run_stop_pin
);
	// Quiet pins, run/stop low through reset
	initial
	begin
		shift_clock_pin = 1'b0;
		serial_data_pin = 1'b0;
		target_select_pin = TGT_IDLE;
		latch_strobe_pin = 1'b0;
		run_stop_pin = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : wait_clk
	// Settle target first so its count clear never meets a shift
	task automatic send(input target_type tgt, input logic [63:0] bits, input int n);
		target_select_pin = tgt;
		wait_clk(6);
		for (int i = 0; i < n; i++)
		begin
			serial_data_pin = bits[i];
			wait_clk(3);
			shift_clock_pin = 1'b1;
			wait_clk(3);
			shift_clock_pin = 1'b0;
		end
		serial_data_pin = ~serial_data_pin; // Released line shows no stale bit
	endtask : send
	task automatic strobe;
		latch_strobe_pin = 1'b1;
		wait_clk(3);
		latch_strobe_pin = 1'b0;
		wait_clk(3);
	endtask : strobe
	task automatic toggle;
		run_stop_pin = ~run_stop_pin;
		wait_clk(8);
	endtask : toggle
endmodule : proc_model

// ### dv/acq_serial_strings_test.sv
`timescale 1ns/1ps
module acq_serial_strings_test;
	import acq_strings_pkg::*;
	localparam int CH = 2;
	logic clock, rst_n, shift_clock_pin, serial_data_pin, latch_strobe_pin, run_stop_pin;
	logic [2:0] target_select_pin;
	sampler_ctrl_type sampler_ctrl [CH];
	sampler_ctrl_type e_smp [CH];
	trigger_ctrl_type trigger_ctrl, e_trg;
	holdoff_ctrl_type holdoff_ctrl, e_hld;
	timebase_ctrl_type timebase_ctrl, e_tb;
	logic run_state;
	logic [6:0] bit_count;
	logic [148:0] notes [$];
	logic [148:0] seen;
	logic [31:0] rnd, w2;
	logic [26:0] pre, post;
	int n_fail, tests_run;
	wire logic [148:0] snap = {sampler_ctrl[0], sampler_ctrl[1], trigger_ctrl, holdoff_ctrl,
		timebase_ctrl};
	wire logic [148:0] want = {e_smp[0], e_smp[1], e_trg, e_hld, e_tb};

	acq_serial_strings #(.CHANNELS(CH)) dut_u (.clock(clock), .rst_n(rst_n),
		.shift_clock_pin(shift_clock_pin), .serial_data_pin(serial_data_pin),
		.target_select_pin(target_select_pin), .latch_strobe_pin(latch_strobe_pin),
		.run_stop_pin(run_stop_pin), .sampler_ctrl(sampler_ctrl), .trigger_ctrl(trigger_ctrl),
		.holdoff_ctrl(holdoff_ctrl), .timebase_ctrl(timebase_ctrl), .run_state(run_state),
		.bit_count(bit_count));
	proc_model proc_u (.clock(clock), .shift_clock_pin(shift_clock_pin),
		.serial_data_pin(serial_data_pin), .target_select_pin(target_select_pin),
		.latch_strobe_pin(latch_strobe_pin), .run_stop_pin(run_stop_pin));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [26:0] g2b(input logic [26:0] g);
		logic [26:0] b;
		b = g;
		for (int i = 25; i >= 0; i--)
			b[i] = b[i + 1] ^ g[i];
		return b;
	endfunction : g2b
	task automatic check(input logic [148:0] got, input logic [148:0] exp_v);
		tests_run++;
		if (got !== exp_v)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp_v);
		end
	endtask : check
	task automatic close_out;
		$display("%0d compares, %0d mismatches", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// Note goes in after shifting, so any early output move finds no note and is checked against want
	task automatic load(input target_type tgt, input logic [31:0] d);
		proc_u.send(tgt, {32'h0000_0000, d}, 32);
		check(149'(bit_count), 149'h20);
		notes.push_back(want);
		proc_u.strobe();
	endtask : load

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Each output change takes the oldest note, or want when no note waits
	initial
	begin
		@(posedge rst_n);
		@(negedge clock);
		seen = snap;
		forever
		begin
			@(negedge clock);
			if (snap !== seen)
			begin
				seen = snap;
				check(snap, (notes.size() > 0) ? notes.pop_front() : want);
			end
		end
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		n_fail++;
		close_out();
	end
	initial
	begin
		n_fail = 0;
		tests_run = 0;
		rst_n = 1'b0;
		rnd = 32'h0AB7;
		e_smp = '{SAMPLER_RESET, SAMPLER_RESET};
		e_trg = TRIGGER_RESET;
		e_hld = HOLDOFF_RESET;
		e_tb = TIMEBASE_RESET;
		repeat (8) @(posedge clock);
		#1;
		rst_n = 1'b1;
		proc_u.wait_clk(2);
		check(snap, want);
		$display("reset test done");
		for (int c = 0; c < CH; c++)
		begin
			rnd = lfsr(rnd);
			e_smp[c] = {rnd[9:0], rnd[10], rnd[11], rnd[12], rnd[23:13],
				rnd[24], rnd[25], rnd[26], rnd[27], rnd[28]};
			load(target_type'(3'(4 + c)), rnd);
		end
		$display("sampler test done");
		rnd = lfsr(rnd);
		e_trg = {rnd[9:0], rnd[10], rnd[11], rnd[12], rnd[13]};
		load(TGT_TRIGGER, rnd);
		for (int s = 0; s < 4; s++)
		begin
			rnd = lfsr(rnd);
			e_hld = {2'(s), g2b(rnd[28:2])};
			load(TGT_HOLDOFF, {rnd[31:2], 2'(s)});
		end
		$display("trigger board test done");
		proc_u.send(TGT_SAMPLER2, {32'h0000_0000, rnd}, 32);
		check(149'(bit_count), 149'h20);
		proc_u.strobe();
		proc_u.send(TGT_IDLE, 64'h0, 0);
		proc_u.strobe();
		for (int k = 0; k < 2; k++)
		begin
			w2 = lfsr(rnd);
			rnd = lfsr(w2);
			pre = g2b({3'h0, rnd[23:0]});
			post = g2b({3'h0, w2[16:0], rnd[31:25]});
			e_tb = {pre[23:0], post[23:0]};
			proc_u.send(TGT_TIMEBASE, {rnd, w2}, 64);
			check(149'(bit_count), 149'h40);
			notes.push_back(want);
			proc_u.toggle();
			check(149'(run_state), 149'(k == 0));
		end
		proc_u.strobe();
		proc_u.wait_clk(4);
		check(149'(notes.size()), 149'h0);
		check(149'(bit_count), 149'h0);
		check(snap, want);
		$display("timebase and refusal test done");
		close_out();
	end
endmodule : acq_serial_strings_test
